// File: rtl/iots_defines.svh
// Constants for the programmed input/output sequencer: widths, timing.
// Assumes inclusion by bare name from the package and design files.
`ifndef IOTS_DEFINES_SVH
`define IOTS_DEFINES_SVH

// Bus widths
`define IOTS_UNIT_W 6
`define IOTS_DATA_W 16
`define IOTS_RET_W 3
// Return vector bit positions
`define IOTS_RET_SYNC 0
`define IOTS_RET_TEST 1
`define IOTS_RET_ACC 2
// Timing: clock period, machine cycle, cycles per immediate instruction
`define IOTS_CLK_NS 20
`define IOTS_MCYC_NS 750
`define IOTS_INSTR_MCYC 4
`define IOTS_INSTR_NS 3000
// Least instruction length in clocks, rounded up
`define IOTS_INSTR_CLKS ((`IOTS_INSTR_MCYC * `IOTS_MCYC_NS + `IOTS_CLK_NS - 1) / `IOTS_CLK_NS)
`define IOTS_TMR_W 8
// Reset values
`define IOTS_RST_UNIT 6'h00
`define IOTS_RST_DATA 16'h0000
`define IOTS_RST_RET 3'h0
`define IOTS_RST_TMR 8'h00

`endif

// File: rtl/iots_pkg.sv
// Types shared by the sequencer and its instruction timer.
// Assumes the defines header sits next to it in rtl/.
`include "iots_defines.svh"
`default_nettype none

package iots_pkg;

  // Instruction type taken from the executing instruction
  typedef enum logic [1:0] {OP_DATA_IN, OP_DATA_OUT, OP_COMMAND, OP_TEST} iots_op_t;

  // Sequencer steps
  typedef enum logic [2:0] {ST_IDLE, ST_CONNECT, ST_CHECK, ST_XFER, ST_TESTRET, ST_RELEASE, ST_DONE} iots_state_t;

  // All sequencer state
  typedef struct packed {
    iots_state_t state;
    logic [`IOTS_UNIT_W-1:0] unit;
    iots_op_t op;
    logic useMem;
    logic waitEn;
    logic [`IOTS_RET_W-1:0] retA;
    logic [`IOTS_RET_W-1:0] retB;
    logic [`IOTS_DATA_W-1:0] dataA;
    logic [`IOTS_DATA_W-1:0] dataB;
    logic testResult;
    logic readyMiss;
    logic wrPulse;
  } iots_regs_t;

  // Timer state
  typedef struct packed {
    logic [`IOTS_TMR_W-1:0] count;
  } iots_tmr_t;

endpackage : iots_pkg

`default_nettype wire

// File: rtl/iots_cycle_timer.sv
// Least-duration timer for one input/output instruction.
// Assumes the sequencer pulses restart when it accepts an instruction.
`include "iots_defines.svh"
`default_nettype none

module iots_cycle_timer (
  input wire logic clock,   // 50 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic ce,      // Clock enable, freezes when low
  input wire logic restart, // Load the full instruction length
  output logic expired      // Least length has elapsed
);
  import iots_pkg::*;

  iots_tmr_t cur_ff; // Registered timer state
  iots_tmr_t nxt_cur; // Next timer state

  // Load on restart, count down to zero otherwise
  always_comb
  begin
    nxt_cur = cur_ff;
    if (ce && restart)
    begin
      nxt_cur.count = `IOTS_TMR_W'(`IOTS_INSTR_CLKS);
    end
    else if (ce && (cur_ff.count != `IOTS_RST_TMR))
    begin
      nxt_cur.count = cur_ff.count - `IOTS_TMR_W'(1);
    end
  end

  // State register
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      cur_ff <= '{count: `IOTS_RST_TMR};
    else
      cur_ff <= nxt_cur;
  end

  assign expired = (cur_ff.count == `IOTS_RST_TMR);

endmodule : iots_cycle_timer

`default_nettype wire

// File: rtl/iots_sequencer.sv
// Programmed input/output sequencer: one word per instruction over the unit bus.
// Assumes the processor holds accWord/memWord stable while busy and that
// bus inputs arrive asynchronously from daisy-chained unit controllers.
//
// Operation
// - Attach unit, transfer once, release before end.
// - 64 units, address taken from instruction.
// - Data passes straight, no holding buffer.
// - Idle means free; no pre-selection needed.
// - One-word transfer lasts 3.0 us plus wait.
// - Instruction selects accumulator or memory.
// - Drive unit, sync, type; unit returns.
// - Check ready after sync, then handshake.
// - Four machine cycles; wait flag holds for ready.
// - Test sends word without ready check.
`include "iots_defines.svh"
`default_nettype none

module iots_sequencer (
  input wire logic clock,                            // 50 MHz clock
  input wire logic reset_n,                          // Master clear, active low
  input wire logic ce,                               // Clock enable, freezes when low
  input wire logic start,                            // Execute instruction request
  input wire logic [`IOTS_UNIT_W-1:0] unitSel,       // Unit number from instruction
  input wire iots_pkg::iots_op_t opSel,              // Instruction type
  input wire logic useMemSel,                        // Memory rather than accumulator
  input wire logic waitSel,                          // Wait flag of instruction
  input wire logic [`IOTS_DATA_W-1:0] accWord,       // Accumulator contents
  input wire logic [`IOTS_DATA_W-1:0] memWord,       // Memory operand
  output logic busy,                                 // Instruction executing
  output logic done,                                 // Instruction complete pulse
  output logic [`IOTS_DATA_W-1:0] inWord,            // Word read from unit
  output logic accWrite,                             // Load accumulator pulse
  output logic memWrite,                             // Store to memory pulse
  output logic readyMiss,                            // Unit was not ready, no transfer
  output logic testResult,                           // Test return after test word
  output logic [`IOTS_UNIT_W-1:0] unitNum,           // Unit number lines
  output logic instSync,                             // Instruction sync
  output logic dataInst,                             // Data instruction line
  output logic cmdInst,                              // Command instruction line
  output logic testInst,                             // Test instruction line
  output logic ioDir,                                // High for output transfer
  output logic waitFlag,                             // Wait flag line
  output logic compDataHere,                         // Computer data here
  output logic compDataAccepted,                     // Computer data accepted
  output logic [`IOTS_DATA_W-1:0] busDataOut,        // Data lines, driven value
  output logic busDataOe_n,                          // Data lines drive, low drives
  input wire logic [`IOTS_DATA_W-1:0] busDataIn,     // Data lines, received value
  input wire logic unitSyncRet,                      // Unit sync return
  input wire logic unitTestRet,                      // Unit test return
  input wire logic unitDataAccepted                  // Unit data accepted
);
  import iots_pkg::*;

  iots_regs_t cur_ff;  // Registered state
  iots_regs_t nxt_cur; // Next state
  logic timerDone;     // Least instruction length elapsed
  logic accept;        // Instruction taken this cycle
  logic syncRet;       // Synchronised sync return
  logic testRet;       // Synchronised test return
  logic dataAcc;       // Synchronised data accepted
  logic isOutput;      // Instruction sends a word

  // Word source chosen by the instruction
  function automatic logic [`IOTS_DATA_W-1:0] pickWord(input logic mem, input logic [`IOTS_DATA_W-1:0] a,
                                                       input logic [`IOTS_DATA_W-1:0] m);
    pickWord = mem ? m : a;
  endfunction : pickWord

  assign accept = ce && start && (cur_ff.state == ST_IDLE);
  assign syncRet = cur_ff.retB[`IOTS_RET_SYNC];
  assign testRet = cur_ff.retB[`IOTS_RET_TEST];
  assign dataAcc = cur_ff.retB[`IOTS_RET_ACC];
  assign isOutput = (cur_ff.op != OP_DATA_IN);

  // Least-duration timer
  iots_cycle_timer u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .restart(accept),
    .expired(timerDone)
  );

  // Sequence control and input synchronisers
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.wrPulse = 1'b0;
    // Two-stage synchronisers on all bus inputs
    nxt_cur.retA = {unitDataAccepted, unitTestRet, unitSyncRet};
    nxt_cur.retB = cur_ff.retA;
    nxt_cur.dataA = busDataIn;
    nxt_cur.dataB = cur_ff.dataA;
    case (cur_ff.state)
      ST_IDLE:
      begin
        // Latch instruction fields, clear flags, go to connect
        if (start)
        begin
          nxt_cur.unit = unitSel;
          nxt_cur.op = opSel;
          nxt_cur.useMem = useMemSel;
          nxt_cur.waitEn = waitSel;
          nxt_cur.readyMiss = 1'b0;
          nxt_cur.testResult = 1'b0;
          nxt_cur.state = ST_CONNECT;
        end
      end
      ST_CONNECT:
      begin
        // Wait for the unit to answer the sync
        if (syncRet)
          nxt_cur.state = (cur_ff.op == OP_TEST) ? ST_XFER : ST_CHECK;
      end
      ST_CHECK:
      begin
        // Ready check on the test return line
        if (testRet)
        begin
          if (cur_ff.op == OP_DATA_IN)
          begin
            nxt_cur.wrPulse = 1'b1;
            nxt_cur.state = ST_RELEASE;
          end
          else
            nxt_cur.state = ST_XFER;
        end
        else if (!cur_ff.waitEn)
        begin
          nxt_cur.readyMiss = 1'b1;
          nxt_cur.state = ST_RELEASE;
        end
      end
      ST_XFER:
      begin
        // Data here held until unit accepts
        if (dataAcc)
          nxt_cur.state = (cur_ff.op == OP_TEST) ? ST_TESTRET : ST_RELEASE;
      end
      ST_TESTRET:
      begin
        // Sample test return after the test word
        nxt_cur.testResult = testRet;
        nxt_cur.state = ST_RELEASE;
      end
      ST_RELEASE:
      begin
        // Disconnect; all returns off and least time spent
        if (!syncRet && !testRet && !dataAcc && timerDone)
          nxt_cur.state = ST_DONE;
      end
      ST_DONE:
        nxt_cur.state = ST_IDLE;
      default:
        nxt_cur.state = ST_IDLE;
    endcase
    if (!ce)
      nxt_cur = cur_ff;
  end

  // State register, cleared by master clear
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      cur_ff <= '{state: ST_IDLE, unit: `IOTS_RST_UNIT, op: OP_DATA_IN, useMem: 1'b0, waitEn: 1'b0,
                  retA: `IOTS_RST_RET, retB: `IOTS_RST_RET, dataA: `IOTS_RST_DATA,
                  dataB: `IOTS_RST_DATA, testResult: 1'b0, readyMiss: 1'b0, wrPulse: 1'b0};
    else
      cur_ff <= nxt_cur;
  end

  // Bus and processor outputs
  assign busy = (cur_ff.state != ST_IDLE);
  assign done = (cur_ff.state == ST_DONE);
  assign instSync = (cur_ff.state == ST_CONNECT) || (cur_ff.state == ST_CHECK) || (cur_ff.state == ST_XFER);
  assign unitNum = busy ? cur_ff.unit : `IOTS_RST_UNIT;
  assign dataInst = instSync && ((cur_ff.op == OP_DATA_IN) || (cur_ff.op == OP_DATA_OUT));
  assign cmdInst = instSync && (cur_ff.op == OP_COMMAND);
  assign testInst = instSync && (cur_ff.op == OP_TEST);
  assign ioDir = instSync && isOutput;
  assign waitFlag = instSync && cur_ff.waitEn && (cur_ff.op != OP_TEST);
  assign compDataHere = (cur_ff.state == ST_XFER);
  assign compDataAccepted = (cur_ff.state == ST_RELEASE) && (cur_ff.op == OP_DATA_IN) && !cur_ff.readyMiss;
  assign busDataOe_n = !compDataHere;
  assign busDataOut = compDataHere ? pickWord(cur_ff.useMem, accWord, memWord) : `IOTS_RST_DATA;
  assign inWord = cur_ff.dataB;
  assign accWrite = cur_ff.wrPulse && !cur_ff.useMem;
  assign memWrite = cur_ff.wrPulse && cur_ff.useMem;
  assign readyMiss = cur_ff.readyMiss;
  assign testResult = cur_ff.testResult;

  // Helper: clocks since the instruction was accepted
  logic [`IOTS_TMR_W-1:0] elapsed_ff;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      elapsed_ff <= `IOTS_RST_TMR;
    else if (accept)
      elapsed_ff <= `IOTS_RST_TMR;
    else if (ce && busy && (elapsed_ff != '1))
      elapsed_ff <= elapsed_ff + `IOTS_TMR_W'(1);
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_attach_first;
    $rose(busy) |-> ##1 instSync;
  endproperty
  a_attach_first: assert property (p_attach_first) else $error("Unit not attached at start");

  property p_release_before_done;
    done |-> (!instSync && !compDataHere && busDataOe_n);
  endproperty
  a_release_before_done: assert property (p_release_before_done) else $error("Unit still attached at done");

  property p_unit_from_instr;
    accept |=> (unitNum == $past(unitSel)) ##1 (unitNum == $past(unitSel, 2)) ##1 (unitNum == $past(unitSel, 3));
  endproperty
  a_unit_from_instr: assert property (p_unit_from_instr) else $error("Unit number not from instruction");

  property p_straight_out;
    compDataHere |-> (busDataOut == (cur_ff.useMem ? memWord : accWord));
  endproperty
  a_straight_out: assert property (p_straight_out) else $error("Output word not passed straight");

  property p_accept_idle;
    (ce && start && !busy) |=> (busy && instSync);
  endproperty
  a_accept_idle: assert property (p_accept_idle) else $error("Idle sequencer refused instruction");

  property p_min_time;
    done |-> (elapsed_ff >= `IOTS_TMR_W'(`IOTS_INSTR_CLKS));
  endproperty
  a_min_time: assert property (p_min_time) else $error("Instruction shorter than four machine cycles");

  property p_unready_skip;
    (ce && cur_ff.state == ST_CHECK && !testRet && !cur_ff.waitEn) |=> (readyMiss && !compDataHere);
  endproperty
  a_unready_skip: assert property (p_unready_skip) else $error("Transfer made to unready unit");

  property p_test_no_ready;
    (ce && cur_ff.state == ST_CONNECT && syncRet && cur_ff.op == OP_TEST) |=> compDataHere;
  endproperty
  a_test_no_ready: assert property (p_test_no_ready) else $error("Test word delayed by ready check");

  property p_returns_off;
    done |-> (!syncRet && !testRet && !dataAcc);
  endproperty
  a_returns_off: assert property (p_returns_off) else $error("Unit returns active at completion");

  property p_write_target;
    (accWrite || memWrite) |-> ((memWrite == cur_ff.useMem) && !(accWrite && memWrite));
  endproperty
  a_write_target: assert property (p_write_target) else $error("Input written to wrong target");

  c_input_done: cover property (accWrite ##[1:300] done);
  c_output_done: cover property (compDataHere ##[1:300] done);
  c_test_done: cover property ((cur_ff.state == ST_TESTRET) ##[1:300] done);
  c_ready_miss: cover property ($rose(readyMiss));

endmodule : iots_sequencer

`default_nettype wire

// File: tb/iots_unit_model.sv
// Behavioural unit controller on the bus, one address.
// Assumes bench settings change at falling edges only.
`default_nettype none
module iots_unit_model (
  input wire logic clock, // Clock
  input wire logic reset_n, // Master clear
  input wire logic [5:0] addr, // Own unit
  input wire logic ready, // Status ready
  input wire logic [3:0] delay, // Pacing
  input wire logic [15:0] inData, // Word sent
  input wire logic [15:0] testMask, // Gated status
  input wire logic [5:0] unitNum, // Unit lines
  input wire logic instSync, // Sync
  input wire logic testInst, // Test line
  input wire logic ioDir, // Output type
  input wire logic compDataHere, // Data here
  input wire logic [15:0] busDataOut, // Computer word
  input wire logic busDataOe_n, // Drives low
  output logic [15:0] busDataIn, // Lines
  output logic unitSyncRet, // Sync return
  output logic unitTestRet, // Test return
  output logic unitDataAccepted, // Accepted
  output logic [15:0] lastWord // Word taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt; // Pacing count
  logic isTest, isIn, testBit; // Latched kind
  logic [15:0] prevBus; // Last line level
  // Gated status on test, else ready
  assign unitTestRet = unitSyncRet & (isTest ? testBit : ready);
  // Released lines toggle, never hold
  assign busDataIn = !busDataOe_n ? busDataOut : (unitSyncRet && isIn ? inData : ~prevBus);
  // Answer, take word, drop returns
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 4'h0;
      {isTest, isIn, testBit, unitSyncRet, unitDataAccepted} <= 5'h00;
      lastWord <= 16'h0000;
      prevBus <= 16'h0000;
    end
    else
    begin
      prevBus <= busDataIn;
      if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (instSync && unitNum == addr && !unitSyncRet)
      begin // Sync answer
        unitSyncRet <= 1'b1;
        isTest <= testInst;
        isIn <= !ioDir;
        cnt <= delay;
      end
      else if (compDataHere && unitSyncRet && !unitDataAccepted)
      begin // Word taken
        lastWord <= busDataOut;
        testBit <= |(busDataOut & testMask);
        unitDataAccepted <= 1'b1;
        cnt <= delay;
      end
      else if (!instSync && !compDataHere && unitSyncRet)
      begin // Disconnected
        unitSyncRet <= 1'b0;
        unitDataAccepted <= 1'b0;
      end
    end
  end
endmodule : iots_unit_model
`default_nettype wire

// File: tb/test_iots_sequencer.sv
// Bench for the sequencer against one modelled unit.
// Assumes one modelled unit; the bench drives clock enable and master clear.
`include "iots_defines.svh"
`default_nettype none
module test_iots_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import iots_pkg::*;
  logic clock, reset_n, start, useMemSel, waitSel, busy, done, accWrite, memWrite, readyMiss, testResult;
  logic instSync, dataInst, cmdInst, testInst, ioDir, waitFlag, compDataHere, compDataAccepted;
  logic busDataOe_n, unitSyncRet, unitTestRet, unitDataAccepted, modelReady, ce;
  logic [5:0] unitSel, unitNum, modelAddr;
  logic [15:0] accWord, memWord, inWord, busDataOut, busDataIn, inData, testMask, lastWord, word;
  logic [3:0] modelDelay;
  logic [10:0] lines; // Unit and type lines
  logic [2:0] rets; // Returns at done
  iots_op_t opSel;
  int errorCnt = 0, numChecks = 0, cycles = 0, cyc, accCnt, memCnt, dacCnt;
  iots_sequencer i_dut (.clock, .reset_n, .ce, .start, .unitSel, .opSel, .useMemSel, .waitSel,
    .accWord, .memWord, .busy, .done, .inWord, .accWrite, .memWrite, .readyMiss, .testResult, .unitNum,
    .instSync, .dataInst, .cmdInst, .testInst, .ioDir, .waitFlag, .compDataHere, .compDataAccepted,
    .busDataOut, .busDataOe_n, .busDataIn, .unitSyncRet, .unitTestRet, .unitDataAccepted);
  iots_unit_model i_unit (.clock, .reset_n, .addr(modelAddr), .ready(modelReady), .delay(modelDelay),
    .inData, .testMask, .unitNum, .instSync, .testInst, .ioDir, .compDataHere, .busDataOut,
    .busDataOe_n, .busDataIn, .unitSyncRet, .unitTestRet, .unitDataAccepted, .lastWord);
  // 50 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Hang limit
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errorCnt++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // One instruction from a falling edge; ready rises at cycle lift
  task automatic run_op(input logic [5:0] u, input iots_op_t op, input logic m, input logic w, input int lift);
    {unitSel, useMemSel, waitSel, modelAddr} = {u, m, w, u};
    opSel = op;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    {cyc, accCnt, memCnt, dacCnt, lines} = {32'h1, 32'h0, 32'h0, 32'h0, 11'h000};
    while (done !== 1'b1 && cyc < 2000)
    begin
      if (instSync === 1'b1 && lines == 11'h000)
        lines = {unitNum, dataInst, cmdInst, testInst, ioDir, waitFlag};
      if (accWrite === 1'b1 || memWrite === 1'b1)
        word = inWord;
      accCnt += (accWrite === 1'b1);
      memCnt += (memWrite === 1'b1);
      dacCnt += (compDataAccepted === 1'b1);
      if (cyc == lift)
        modelReady = 1'b1;
      @(negedge clock);
      cyc++;
    end
    chk("done", done, 1);
    rets = {unitSyncRet, unitTestRet, unitDataAccepted};
    @(negedge clock);
  endtask : run_op
  task automatic t_input;
    for (int m = 0; m < 2; m++)
    begin
      inData = m ? 16'h3C5A : 16'hA5C3;
      run_op(6'h00, OP_DATA_IN, m[0], 1'b0, 0);
      chk("acc write", accCnt, 1 - m);
      chk("mem write", memCnt, m);
      chk("input word", word, inData);
      chk("lines", lines, {6'h00, 5'h10});
      chk("length", cyc >= `IOTS_INSTR_CLKS, 1);
      chk("returns", rets, 0);
      chk("data accepted", dacCnt > 0, 1);
    end
    $display("input test over");
  endtask : t_input
  task automatic t_output;
    for (int k = 0; k < 4; k++)
    begin
      run_op(6'h2A, k[1] ? OP_COMMAND : OP_DATA_OUT, k[0], 1'b1, 0);
      chk("unit word", lastWord, k[0] ? memWord : accWord);
      chk("no store", accCnt + memCnt + dacCnt, 0);
      chk("lines", lines, {6'h2A, !k[1], k[1], 3'h3});
    end
    $display("output test over");
  endtask : t_output
  task automatic t_test;
    modelReady = 1'b0;
    accWord = 16'h0F0F;
    run_op(6'h15, OP_DATA_OUT, 1'b0, 1'b0, 0);
    chk("ready miss", readyMiss, 1);
    chk("withheld", lastWord, 16'hFEDC);
    chk("no accept", dacCnt, 0);
    for (int t = 0; t < 2; t++)
    begin
      accWord = t ? 16'h0001 : 16'h0010;
      run_op(6'h15, OP_TEST, 1'b0, 1'b0, 0);
      chk("test word", lastWord, accWord);
      chk("test status", testResult, 1 - t);
    end
    $display("test test over");
  endtask : t_test
  task automatic t_wait;
    modelDelay = 4'h5;
    inData = 16'h8001;
    run_op(6'h3F, OP_DATA_IN, 1'b1, 1'b1, 400);
    chk("held", cyc > 400, 1);
    chk("stored", {memCnt[15:0], word}, {16'h0001, 16'h8001});
    chk("no miss", readyMiss, 0);
    chk("free", busy, 0);
    run_op(6'h01, OP_DATA_IN, 1'b0, 1'b0, 0);
    chk("next unit", lines[10:5], 6'h01);
    chk("next store", accCnt, 1);
    $display("wait test over");
  endtask : t_wait
  // Absent unit hangs the sequencer until master clear
  task automatic t_clear;
    {unitSel, modelAddr} = {6'h09, 6'h0A};
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    repeat (20) @(negedge clock);
    chk("hung", {busy, instSync}, 2'h3);
    reset_n = 1'b0;
    @(negedge clock);
    chk("cleared", {busy, instSync, compDataHere, unitNum}, 9'h000);
    reset_n = 1'b1;
    @(negedge clock);
    $display("clear test over");
  endtask : t_clear
  // Start ignored while frozen, then a new command taken once enabled
  task automatic t_freeze;
    ce = 1'b0;
    start = 1'b1;
    repeat (3) @(negedge clock);
    chk("frozen", {busy, instSync}, 2'h0);
    start = 1'b0;
    ce = 1'b1;
    @(negedge clock);
    run_op(6'h07, OP_COMMAND, 1'b1, 1'b0, 0);
    chk("thawed", lastWord, memWord);
    $display("freeze test over");
  endtask : t_freeze
  // Main sequence
  initial
  begin
    {reset_n, start, useMemSel, waitSel, unitSel, modelAddr, inData, testMask} = 0;
    {accWord, memWord, modelReady, modelDelay} = {16'h1234, 16'hFEDC, 1'b1, 4'h0};
    opSel = OP_DATA_IN;
    ce = 1'b1;
    repeat (6) @(negedge clock);
    chk("reset", {busy, done, instSync, busDataOe_n, unitNum}, {4'h1, 6'h00});
    reset_n = 1'b1;
    @(negedge clock);
    testMask = 16'h0010;
    t_input();
    t_output();
    t_test();
    t_wait();
    t_clear();
    t_freeze();
    finish_test();
  end
endmodule : test_iots_sequencer
`default_nettype wire
